// ==== ccpc_pkg.sv ====
// Package for the capture/compare/PWM control block: register map,
// control field layout, mode codes and the per-pin output record.
// Assumes a 32-bit APB slave at word-aligned offsets.
package ccpc_pkg;
   localparam logic [7:0] CCPC_OFS_CTRL = 8'h00;
   localparam logic [7:0] CCPC_OFS_CMPV = 8'h04;
   localparam logic [7:0] CCPC_OFS_DUTY = 8'h08;
   localparam logic [7:0] CCPC_OFS_CAPT = 8'h0c;
   localparam logic [7:0] CCPC_OFS_STAT = 8'h10;
   localparam logic [7:0] CCPC_OFS_PER = 8'h14;
   localparam logic [7:0] CCPC_CTRL_RST = 8'h00;
   localparam int CCPC_FSEL_LSB = 0;
   localparam int CCPC_DLOW_LSB = 4;
   localparam int CCPC_STEER_LSB = 6;
   localparam logic [3:0] CCPC_PRESC4 = 4'h3;
   localparam logic [3:0] CCPC_PRESC16 = 4'hf;

   localparam logic [3:0] FS_OFF = 4'h0;
   localparam logic [3:0] FS_CMP_TOGGLE = 4'h2;
   localparam logic [3:0] FS_CAP_FALL = 4'h4;
   localparam logic [3:0] FS_CAP_RISE = 4'h5;
   localparam logic [3:0] FS_CAP_RISE4 = 4'h6;
   localparam logic [3:0] FS_CAP_RISE16 = 4'h7;
   localparam logic [3:0] FS_CMP_SET = 4'h8;
   localparam logic [3:0] FS_CMP_CLR = 4'h9;
   localparam logic [3:0] FS_CMP_SWI = 4'ha;
   localparam logic [3:0] FS_CMP_SPEV = 4'hb;

   localparam logic [1:0] ST_SINGLE = 2'h0;
   localparam logic [1:0] ST_FULL_FWD = 2'h1;
   localparam logic [1:0] ST_HALF = 2'h2;
   localparam logic [1:0] ST_FULL_REV = 2'h3;

   typedef struct packed {
      logic [1:0] output_steering_config;
      logic [1:0] duty_low_bits;
      logic [3:0] function_select;
   } ccpc_ctrl_t;

   // One pin: value and whether the module owns it (else port pin)
   typedef struct packed {
      logic val;
      logic own;
   } ccpc_pin_t;
endpackage : ccpc_pkg

// ==== ccpc_core.sv ====
// Overview of operation
// R01: Capture/compare use 16-bit timebase; PWM 8-bit.
// R02: Mode 0000 off, module state reset.
// R03: 0010 toggles compare output, sets flag.
// R04: 0100 captures on every falling edge.
// R05: Rising edge capture; 0111 every 16th.
// R06: 1000 sets compare output, sets flag.
// R07: Software interrupt compare: flag only, pin untouched.
// R08: 1011 special event: flag, timer reset, conversion.
// R09: 11xx PWM; low bits choose pair polarities.
// R10: Non-PWM: A is module pin, B-D ports.
// R11: Config 00: only A modulated.
// R12: Config 01: D modulated, A active, B,C inactive.
// R13: Config 10: A and B modulated, C,D ports.
// R14: Bits 5:4 are duty low bits.
// R15: Capture copies 16-bit count, sets flag.
// R16: 0110 captures every fourth rising edge.
// R17: 1001 clears compare output on match.
// R18: Special event does not set overflow flag.
// R19: Config 11: B modulated, C active, A,D inactive.
// R20: Reserved codes behave as off.
//
// File holds the whole control block with its APB slave and PWM engine.
// Assumes capture_timebase count comes in synchronous to i_sys_clk and
// that the timebase owner honours o_timebase_reset.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module ccpc_core
   import ccpc_pkg::*;
#(
   parameter int TB_W = 16,
   parameter int PWM_W = 8
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [TB_W-1:0] i_capture_timebase_count,
   input wire logic i_pwm_tick,
   input wire logic i_module_pin,
   input wire logic i_converter_enabled,
   output logic o_out_a,
   output logic o_out_a_oe,
   output logic o_out_b,
   output logic o_out_b_oe,
   output logic o_out_c,
   output logic o_out_c_oe,
   output logic o_out_d,
   output logic o_out_d_oe,
   output logic o_module_irq_flag,
   output logic o_timebase_reset,
   output logic o_start_conversion
);
   ccpc_ctrl_t ctrl_q;
   logic [TB_W-1:0] cmpv_q, capt_q;
   logic [PWM_W-1:0] duty_high_reg_q, period_q;
   logic [PWM_W+1:0] duty_latch_q;
   logic [PWM_W+1:0] pwm_cnt_q;
   logic [3:0] presc_q;
   logic pin_q, cmp_out_q, pwm_out_q, flag_q, match_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;
   ccpc_pin_t [3:0] pins_q, pins_d;

   // Bus decode
   // Write lands at the edge where the master samples pready high
   wire wr_en = psel & penable & pwrite & pready_q;
   wire rd_en = psel & penable & ~pwrite & ~pready_q;
   wire hit_ctrl = paddr == CCPC_OFS_CTRL;
   wire hit_cmpv = paddr == CCPC_OFS_CMPV;
   wire hit_duty = paddr == CCPC_OFS_DUTY;
   wire hit_capt = paddr == CCPC_OFS_CAPT;
   wire hit_stat = paddr == CCPC_OFS_STAT;
   wire hit_per = paddr == CCPC_OFS_PER;
   wire hit_any = hit_ctrl | hit_cmpv | hit_duty | hit_capt | hit_stat |
      hit_per;
   wire [3:0] fsel = ctrl_q.function_select;
   wire is_pwm = fsel[3:2] == 2'b11; // [R09]
   wire is_cap = fsel[3:2] == 2'b01; // [R04] [R05]
   wire is_cmp = (fsel == FS_CMP_TOGGLE) | (fsel[3:2] == 2'b10); // [R20]

   // Edge detect on the registered pin
   wire rise = i_module_pin & ~pin_q;
   wire fall = ~i_module_pin & pin_q;
   wire presc_wrap4 = presc_q[1:0] == CCPC_PRESC4[1:0];
   wire presc_wrap16 = presc_q == CCPC_PRESC16;
   wire cap_evt = is_cap & ((fsel == FS_CAP_FALL) ? fall : // [R04]
      (fsel == FS_CAP_RISE) ? rise : // [R05]
      (fsel == FS_CAP_RISE4) ? (rise & presc_wrap4) : // [R16]
      (rise & presc_wrap16)); // [R05]

   // Compare uses the 16-bit capture timebase [R01]
   wire tb_match = i_capture_timebase_count == cmpv_q;
   wire cmp_evt = is_cmp & tb_match & ~match_q;
   wire spev = cmp_evt & (fsel == FS_CMP_SPEV); // [R08]

   // PWM on the 8-bit period timebase, 2 fractional bits [R01] [R14]
   wire [PWM_W-1:0] pwm_hi = pwm_cnt_q[PWM_W+1:2];
   wire pwm_end = i_pwm_tick & (pwm_hi == period_q) &
      (pwm_cnt_q[1:0] == 2'b11);
   wire [PWM_W+1:0] duty_full = {duty_high_reg_q, ctrl_q.duty_low_bits};
   wire pol_ac = fsel[1]; // [R09]
   wire pol_bd = fsel[0]; // [R09]
   wire pwm_mod = pwm_out_q;

   always_comb begin
      pins_d = '0;
      if (is_pwm) begin
         case (ctrl_q.output_steering_config)
            ST_SINGLE: begin
               pins_d[0] = '{pwm_mod ^ pol_ac, 1'b1}; // [R11]
            end
            ST_FULL_FWD: begin
               pins_d[0] = '{~pol_ac, 1'b1}; // [R12]
               pins_d[1] = '{pol_bd, 1'b1};
               pins_d[2] = '{pol_ac, 1'b1};
               pins_d[3] = '{pwm_mod ^ pol_bd, 1'b1};
            end
            ST_HALF: begin
               pins_d[0] = '{pwm_mod ^ pol_ac, 1'b1}; // [R13]
               pins_d[1] = '{~pwm_mod ^ pol_bd, 1'b1};
            end
            ST_FULL_REV: begin
               pins_d[0] = '{pol_ac, 1'b1}; // [R19]
               pins_d[1] = '{pwm_mod ^ pol_bd, 1'b1};
               pins_d[2] = '{~pol_ac, 1'b1};
               pins_d[3] = '{pol_bd, 1'b1};
            end
            default: begin
               pins_d = '0;
            end
         endcase
      end else if (is_cmp & (fsel != FS_CMP_SWI) & (fsel != FS_CMP_SPEV)) begin
         pins_d[0] = '{cmp_out_q, 1'b1}; // [R10]
      end
      // Capture, special event and software interrupt leave A as input [R07]
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         ctrl_q <= CCPC_CTRL_RST;
         cmpv_q <= '0;
         duty_high_reg_q <= '0;
         period_q <= '0;
      end else if (wr_en) begin
         if (hit_ctrl)
            ctrl_q <= pwdata[7:0];
         if (hit_cmpv)
            cmpv_q <= pwdata[TB_W-1:0];
         if (hit_duty)
            duty_high_reg_q <= pwdata[PWM_W-1:0];
         if (hit_per)
            period_q <= pwdata[PWM_W-1:0];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= psel & penable & ~pready_q;
         pslverr_q <= psel & penable & ~pready_q & ~hit_any;
         if (rd_en) begin
            prdata_q <= '0;
            if (hit_ctrl)
               prdata_q[7:0] <= ctrl_q;
            if (hit_cmpv)
               prdata_q[TB_W-1:0] <= cmpv_q;
            if (hit_duty)
               prdata_q[PWM_W-1:0] <= duty_high_reg_q;
            if (hit_capt)
               prdata_q[TB_W-1:0] <= capt_q;
            if (hit_stat)
               prdata_q[2:0] <= {pwm_out_q, cmp_out_q, flag_q};
            if (hit_per)
               prdata_q[PWM_W-1:0] <= period_q;
         end
      end
   end

   // Flag: hardware set beats software write-one-to-clear
   wire flag_clr = wr_en & hit_stat & pwdata[0];
   wire flag_set = cap_evt | cmp_evt; // [R03] [R06] [R07] [R08] [R15]
   always_ff @(posedge i_sys_clk) begin
      if (i_reset)
         flag_q <= 1'b0;
      else
         flag_q <= flag_set | (flag_q & ~flag_clr);
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         pin_q <= 1'b0;
         presc_q <= '0;
         capt_q <= '0;
      end else begin
         pin_q <= i_module_pin;
         // Prescaler cleared whenever not capturing [R02]
         if (!is_cap)
            presc_q <= '0;
         else if (rise)
            presc_q <= presc_q + 4'h1;
         if (cap_evt)
            capt_q <= i_capture_timebase_count; // [R15]
      end
   end

   // Match is edge-qualified so a stalled timer fires once per match
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         match_q <= 1'b0;
         cmp_out_q <= 1'b0;
      end else begin
         match_q <= is_cmp & tb_match;
         if (!is_cmp)
            cmp_out_q <= 1'b0; // [R02]
         else if (cmp_evt) begin
            case (fsel)
               FS_CMP_TOGGLE: cmp_out_q <= ~cmp_out_q; // [R03]
               FS_CMP_SET: cmp_out_q <= 1'b1; // [R06]
               FS_CMP_CLR: cmp_out_q <= 1'b0; // [R17]
               default: cmp_out_q <= cmp_out_q;
            endcase
         end
      end
   end

   // Duty latched at period end; zero duty never raises the output
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         pwm_cnt_q <= '0;
         duty_latch_q <= '0;
         pwm_out_q <= 1'b0;
      end else if (!is_pwm) begin
         pwm_cnt_q <= '0;
         duty_latch_q <= '0;
         pwm_out_q <= 1'b0;
      end else if (pwm_end) begin
         pwm_cnt_q <= '0;
         duty_latch_q <= duty_full; // [R14]
         pwm_out_q <= duty_full != '0;
      end else if (i_pwm_tick) begin
         pwm_cnt_q <= pwm_cnt_q + 1'b1;
         if (pwm_cnt_q + 1'b1 >= duty_latch_q)
            pwm_out_q <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         pins_q <= '0;
         o_timebase_reset <= 1'b0;
         o_start_conversion <= 1'b0;
      end else begin
         pins_q <= pins_d;
         // Timebase clear only; overflow flag belongs to the timer [R18]
         o_timebase_reset <= spev; // [R08]
         o_start_conversion <= spev & i_converter_enabled; // [R08]
      end
   end

   assign o_out_a = pins_q[0].val;
   assign o_out_a_oe = pins_q[0].own;
   assign o_out_b = pins_q[1].val;
   assign o_out_b_oe = pins_q[1].own;
   assign o_out_c = pins_q[2].val;
   assign o_out_c_oe = pins_q[2].own;
   assign o_out_d = pins_q[3].val;
   assign o_out_d_oe = pins_q[3].own;
   assign o_module_irq_flag = flag_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
endmodule : ccpc_core
`default_nettype wire

// ==== ccpc_chk.sv ====
// Port checker for ccpc_core, bound after the module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module ccpc_chk (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic o_out_a_oe,
   input wire logic o_out_b_oe,
   input wire logic o_out_c_oe,
   input wire logic o_out_d_oe,
   input wire logic o_module_irq_flag,
   input wire logic o_timebase_reset,
   input wire logic o_start_conversion
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   sequence s_wait; psel && penable && !pready; endsequence
   sequence s_ans; pready ##1 !pready; endsequence
   a_one_wait: assert property (s_wait |=> s_ans) else $error("apb wait");
   a_err_ready: assert property (pslverr |-> pready) else $error("slverr");
   a_b_needs_a: assert property (
      o_out_b_oe |-> o_out_a_oe) else $error("b without a");
   a_c_needs_b: assert property (
      o_out_c_oe |-> o_out_b_oe) else $error("c without b");
   a_cd_pair: assert property (
      o_out_c_oe == o_out_d_oe) else $error("c d differ");
   a_conv_tbr: assert property (
      o_start_conversion |-> o_timebase_reset) else $error("lone conv");
   a_tbr_pulse: assert property (
      o_timebase_reset |=> !o_timebase_reset) else $error("long reset");
   a_tbr_flag: assert property (
      o_timebase_reset |-> ##[0:2] o_module_irq_flag) else $error("no flag");
   // Reset itself is the cause here, so this one is never disabled
   a_reset_quiet: assert property (disable iff (1'b0)
      i_reset |=> !o_module_irq_flag && !o_out_a_oe && !o_timebase_reset)
      else $error("reset left outputs");
endmodule : ccpc_chk
bind ccpc_core ccpc_chk u_ccpc_chk (.i_sys_clk, .i_reset, .psel, .penable,
   .pready, .pslverr, .o_out_a_oe, .o_out_b_oe, .o_out_c_oe, .o_out_d_oe,
   .o_module_irq_flag, .o_timebase_reset, .o_start_conversion);
`default_nettype wire

// ==== ccpc_pin_model.sv ====
// Far side: capture pin driver and 16-bit capture timebase.
// Pin follows the bench level one edge later; count may be frozen.
`timescale 1ns/100ps
`default_nettype none
module ccpc_pin_model (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_hold,
   input wire logic i_lvl,
   input wire logic i_timebase_reset,
   output logic [15:0] o_count,
   output logic o_pin
);
   always_ff @(posedge i_sys_clk) begin
      o_pin <= i_lvl;
      if (i_reset || i_timebase_reset) begin
         o_count <= 16'h0000;
      end else if (!i_hold) begin
         o_count <= o_count + 16'h0001;
      end
   end
endmodule : ccpc_pin_model
`default_nettype wire

// ==== tb_capture_compare_pwm_control.sv ====
// Bench: control rows, capture edges, compare runs, resets.
// Assumes the pin model as far side and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb_capture_compare_pwm_control;
   import ccpc_pkg::*;
   logic i_sys_clk = 1'b0, i_reset = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, hold = 1'b1, lvl = 1'b0, zero = 1'b0, adc = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd;
   logic err;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, pin, flag, tbr, conv;
   wire logic [15:0] cnt;
   wire logic [3:0] oe, val;
   int miscompares = 0, cmp_count = 0, convs = 0, tbrs = 0;
   typedef struct packed {
      logic [7:0] c;
      logic [3:0] oe, om, v, vm;
   } ccpc_row_t;
   ccpc_row_t r;
   ccpc_row_t rows [8] = '{'{8'h00, 4'h0, 4'hf, 4'h0, 4'h0},
      '{8'h01, 4'h0, 4'hf, 4'h0, 4'h0}, '{8'hc5, 4'h0, 4'h7, 4'h0, 4'h0},
      '{8'h3c, 4'h8, 4'hf, 4'h0, 4'h0}, '{8'h4c, 4'hf, 4'hf, 4'h8, 4'he},
      '{8'h4f, 4'hf, 4'hf, 4'h6, 4'he}, '{8'h8c, 4'hc, 4'hf, 4'h0, 4'h0},
      '{8'hcc, 4'hf, 4'hf, 4'h2, 4'hb}};
   ccpc_core u_ccpc_core (.i_sys_clk, .i_reset, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr,
      .i_capture_timebase_count(cnt), .i_pwm_tick(1'b0),
      .i_module_pin(pin), .i_converter_enabled(adc),
      .o_out_a(val[3]), .o_out_a_oe(oe[3]), .o_out_b(val[2]),
      .o_out_b_oe(oe[2]), .o_out_c(val[1]), .o_out_c_oe(oe[1]),
      .o_out_d(val[0]), .o_out_d_oe(oe[0]), .o_module_irq_flag(flag),
      .o_timebase_reset(tbr), .o_start_conversion(conv));
   ccpc_pin_model u_ccpc_pin_model (.i_sys_clk, .i_reset(i_reset | zero),
      .i_hold(hold), .i_lvl(lvl), .i_timebase_reset(tbr), .o_count(cnt),
      .o_pin(pin));
   initial forever #2 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      if (tbr === 1'b1) tbrs++;
      if (conv === 1'b1) convs++;
   end
   task end_sim;
      if (miscompares == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Idle cycle after release, so the next setup never collides
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge i_sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) miscompares++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_sys_clk);
   endtask : apb
   task pin_to(input logic l);
      lvl <= l;
      repeat (4) @(posedge i_sys_clk);
   endtask : pin_to
   // Off first: changing prescale alone keeps the old edge count
   task capt(input logic [7:0] m, input int n);
      apb(1'b1, CCPC_OFS_CTRL, 32'h0);
      apb(1'b1, CCPC_OFS_CTRL, 32'(m));
      apb(1'b1, CCPC_OFS_STAT, 32'h1);
      repeat (n - 1) begin
         pin_to(1'b1);
         pin_to(1'b0);
      end
      chk(32'(flag), 32'h0);
      pin_to(1'b1);
      chk(32'(flag), 32'h1);
      pin_to(1'b0);
   endtask : capt
   task cmp(input logic [7:0] m, input logic e);
      zero <= 1'b1;
      @(posedge i_sys_clk);
      zero <= 1'b0;
      apb(1'b1, CCPC_OFS_CTRL, 32'(m));
      apb(1'b1, CCPC_OFS_STAT, 32'h1);
      hold <= 1'b0;
      repeat (30) @(posedge i_sys_clk);
      hold <= 1'b1;
      chk(32'(flag), 32'h1);
      if (e !== 1'bx) chk(32'(val[3]), 32'(e));
      chk(32'(oe[3]), 32'(m != 8'h0a && m != 8'h0b));
   endtask : cmp
   initial begin
      #100000;
      miscompares++;
      end_sim();
   end
   initial begin
      repeat (10) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      apb(1'b0, CCPC_OFS_CTRL, 32'h0);
      chk(rd, 32'(CCPC_CTRL_RST));
      apb(1'b0, 8'h18, 32'h0);
      chk({rd[31:1], err}, 32'h1);
      foreach (rows[i]) begin
         r = rows[i];
         apb(1'b1, CCPC_OFS_CTRL, 32'(r.c));
         apb(1'b0, CCPC_OFS_CTRL, 32'h0);
         chk(rd, 32'(r.c));
         chk(32'(oe & r.om), 32'(r.oe & r.om));
         chk(32'(val & r.vm), 32'(r.v));
      end
      hold <= 1'b0;
      repeat (37) @(posedge i_sys_clk);
      hold <= 1'b1;
      apb(1'b1, CCPC_OFS_CTRL, 32'h4);
      apb(1'b1, CCPC_OFS_STAT, 32'h1);
      pin_to(1'b1);
      chk(32'(flag), 32'h0);
      pin_to(1'b0);
      chk(32'(flag), 32'h1);
      apb(1'b0, CCPC_OFS_CAPT, 32'h0);
      chk(rd, {16'h0, cnt});
      capt(8'h05, 1);
      capt(8'h06, 4);
      capt(8'h07, 16);
      apb(1'b1, CCPC_OFS_CMPV, 32'd20);
      cmp(8'h0a, 1'b0);
      cmp(8'h02, 1'b1);
      cmp(8'h09, 1'b0);
      cmp(8'h08, 1'b1);
      cmp(8'h0b, 1'bx);
      chk(32'(tbrs), 32'h1);
      chk(32'(convs), 32'h1);
      adc <= 1'b0;
      cmp(8'h0b, 1'bx);
      chk(32'(convs), 32'h1);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      apb(1'b0, CCPC_OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      chk(32'(flag), 32'h0);
      end_sim();
   end
endmodule : tb_capture_compare_pwm_control
`default_nettype wire
